// File: emif_ctl_pkg.sv
// constants and types of the external memory control pin block
// assumes a single 125 MHz clock and a classic wishbone register port
package emif_ctl_pkg;

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SPACE = 8'h04;
    localparam logic [7:0] OFS_ADDR = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // ************************************************************
    // field positions, width reset value and clock divider half periods
    // ************************************************************
    localparam int CTRL_DIV_LSB = 0;
    localparam int CTRL_NOSD_BIT = 2;
    localparam int CTRL_SREF_BIT = 3;
    localparam int CTRL_GPO_BIT = 4;
    localparam int CTRL_WID_LSB = 5;
    localparam int SPACE_RDSEL_LSB = 8;
    localparam int CMD_WE_BIT = 0;
    localparam int CMD_PX_BIT = 1;
    localparam int CMD_SIZE_LSB = 2;
    localparam int STAT_DONE_BIT = 2;
    localparam logic [1:0] WIDTH_RST = 2'h3;
    localparam int CORE4_HALF = 2;
    localparam int CORE6_HALF = 3;

    // ************************************************************
    // enumerations
    // ************************************************************
    typedef enum logic [1:0] {
        SRC_EXT = 2'h0,
        SRC_CORE4 = 2'h1,
        SRC_CORE6 = 2'h2
    } clk_src_t;

    typedef enum logic [1:0] {
        DIV_1 = 2'h0,
        DIV_2 = 2'h1,
        DIV_4 = 2'h2
    } div_sel_t;

    typedef enum logic [1:0] {
        MEM_ASYNC = 2'h0,
        MEM_SDRAM = 2'h1,
        MEM_SYNC = 2'h2
    } mem_type_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ACTIVE = 3'b001,
        ST_STROBE = 3'b010,
        ST_DONE = 3'b011,
        ST_HOLD_OFF = 3'b100,
        ST_HOLD = 3'b101
    } fsm_t;

    // strap code 01 picks core/4, 10 core/6, the rest the external clock
    function automatic clk_src_t strap_decode(input logic [1:0] s);
        case (s)
            2'h1: strap_decode = SRC_CORE4;
            2'h2: strap_decode = SRC_CORE6;
            default: strap_decode = SRC_EXT;
        endcase
    endfunction

endpackage

// File: emif_ctl.sv
// control, clocking and arbitration pins of the wide memory interface
// assumes pin inputs synchronous to clk_i and a classic wishbone master
`timescale 1ns/1ns
`default_nettype none
module emif_ctl
    import emif_ctl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    output logic wb_ack_o,
    input wire logic [1:0] clk_src_straps_i,
    input wire logic if_clk_in_i,
    output logic if_clk_out_full_o,
    output logic if_clk_out_div_o,
    output logic [3:0] chip_en_n_o,
    output logic [7:0] byte_en_n_o,
    output logic pin_rd_n_o,
    output logic pin_oe_n_o,
    output logic pin_we_n_o,
    output logic sdram_clk_en_o,
    output logic fifo_out_en_space3_n_o,
    output logic periph_xfer_out_n_o,
    output logic ctl_oe_n_o,
    input wire logic async_ready_in_i,
    input wire logic hold_req_in_i,
    output logic hold_ack_out_o,
    output logic bus_req_out_o
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic strap_done;
        clk_src_t clk_src;
        logic [1:0] div_cnt;
        logic src_lvl;
        logic div_lvl;
        logic div_ph;
        div_sel_t div_sel;
        logic no_sdram;
        logic self_ref;
        logic gpo_val;
        logic [1:0] mem_width;
        logic [7:0] space_type;
        logic [3:0] rd_sel;
        logic [31:0] addr;
        logic cmd_we;
        logic cmd_px;
        logic [1:0] cmd_size;
        logic pend;
        logic done;
        fsm_t fsm;
        logic ack;
        logic [31:0] rdata;
        logic [3:0] ce_n;
        logic [7:0] be_n;
        logic rd_n;
        logic oe_n;
        logic we_n;
        logic fifo3_n;
        logic px_n;
        logic bus_off;
        logic hold_ack;
    } state_t;

    state_t q, d;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        merge = (old & ~m) | (nw & m);
    endfunction

    function automatic logic [7:0] be_calc(input logic [2:0] lo,
                                           input logic [1:0] wid,
                                           input logic [1:0] size);
        logic [15:0] szm;
        logic [15:0] wm;
        logic [2:0] lane;
        logic [3:0] wb;
        wb = 4'h1 << wid;
        szm = (16'h0001 << (4'h1 << size)) - 16'h0001;
        wm = (16'h0001 << wb) - 16'h0001;
        lane = lo & 3'(wb - 4'h1);
        be_calc = 8'((szm << lane) & wm);
    endfunction

    logic sel_ok;
    logic tick;
    logic [1:0] space;
    mem_type_t mtype;
    logic [31:0] ctrl_w;
    logic [31:0] space_w;
    logic [31:0] cmd_w;
    logic [31:0] stat_w;
    logic [31:0] wv;
    logic done_set;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        d = q;
        sel_ok = wb_cyc_i && wb_stb_i && !q.ack;
        done_set = 1'b0;
        ctrl_w = {25'h0, q.mem_width, q.gpo_val, q.self_ref, q.no_sdram,
                  q.div_sel};
        space_w = {20'h0, q.rd_sel, q.space_type};
        cmd_w = {28'h0, q.cmd_size, q.cmd_px, q.cmd_we};
        stat_w = {24'h0, q.fsm, q.clk_src, q.done, q.hold_ack, q.pend};
        wv = 32'h0;
        // clock source caught once after reset
        if (!q.strap_done) begin
            d.strap_done = 1'b1;
            d.clk_src = strap_decode(clk_src_straps_i);
        end
        // interface clock level from the selected source
        case (q.clk_src)
            SRC_CORE4: begin
                d.div_cnt = (q.div_cnt == 2'(CORE4_HALF - 1)) ? 2'h0
                            : q.div_cnt + 2'h1;
                d.src_lvl = (q.div_cnt == 2'(CORE4_HALF - 1)) ? !q.src_lvl
                            : q.src_lvl;
            end
            SRC_CORE6: begin
                d.div_cnt = (q.div_cnt == 2'(CORE6_HALF - 1)) ? 2'h0
                            : q.div_cnt + 2'h1;
                d.src_lvl = (q.div_cnt == 2'(CORE6_HALF - 1)) ? !q.src_lvl
                            : q.src_lvl;
            end
            default: begin
                d.div_cnt = 2'h0;
                d.src_lvl = if_clk_in_i;
            end
        endcase
        tick = d.src_lvl && !q.src_lvl;
        // divided output clock
        case (q.div_sel)
            DIV_2: begin
                if (tick) begin
                    d.div_lvl = !q.div_lvl;
                end
            end
            DIV_4: begin
                if (tick) begin
                    d.div_ph = !q.div_ph;
                    if (q.div_ph) begin
                        d.div_lvl = !q.div_lvl;
                    end
                end
            end
            default: begin
                d.div_lvl = d.src_lvl;
            end
        endcase
        // access sequencer
        space = q.addr[29:28];
        mtype = mem_type_t'(q.space_type[2*space +: 2]);
        case (q.fsm)
            ST_IDLE: begin
                if (hold_req_in_i) begin
                    d.fsm = ST_HOLD_OFF;
                end else if (q.pend && tick) begin
                    d.fsm = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (tick) begin
                    d.fsm = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (tick && (mtype != MEM_ASYNC || async_ready_in_i)) begin
                    d.fsm = ST_DONE;
                end
            end
            ST_DONE: begin
                if (tick) begin
                    d.fsm = ST_IDLE;
                    d.pend = 1'b0;
                    done_set = 1'b1;
                end
            end
            ST_HOLD_OFF: begin
                d.fsm = ST_HOLD;
            end
            ST_HOLD: begin
                if (!hold_req_in_i) begin
                    d.fsm = ST_IDLE;
                end
            end
            default: begin
                d.fsm = ST_IDLE;
            end
        endcase
        d.bus_off = d.fsm == ST_HOLD_OFF || d.fsm == ST_HOLD;
        d.hold_ack = q.bus_off && d.fsm == ST_HOLD;
        // pin decode for the coming state
        d.ce_n = 4'hf;
        d.be_n = 8'hff;
        d.rd_n = 1'b1;
        d.oe_n = 1'b1;
        d.we_n = 1'b1;
        d.fifo3_n = 1'b1;
        d.px_n = 1'b1;
        if (d.fsm == ST_ACTIVE || d.fsm == ST_STROBE || d.fsm == ST_DONE) begin
            d.ce_n = ~(4'h1 << space);
            d.be_n = ~be_calc(q.addr[2:0], q.mem_width, q.cmd_size);
        end
        if (d.fsm == ST_ACTIVE && mtype == MEM_SDRAM) begin
            d.oe_n = 1'b0;
        end
        if (d.fsm == ST_STROBE) begin
            d.px_n = !q.cmd_px;
            case (mtype)
                MEM_SDRAM: begin
                    d.rd_n = 1'b0;
                    d.we_n = !q.cmd_we;
                end
                MEM_SYNC: begin
                    d.rd_n = q.rd_sel[space] ? q.cmd_we : 1'b0;
                    d.oe_n = q.cmd_we;
                    d.we_n = !q.cmd_we;
                    d.fifo3_n = !(space == 2'h3 && !q.cmd_we);
                end
                default: begin
                    d.rd_n = q.cmd_we;
                    d.oe_n = q.cmd_we;
                    d.we_n = !q.cmd_we;
                end
            endcase
        end
        // register port
        d.ack = sel_ok;
        if (sel_ok) begin
            case (wb_adr_i)
                OFS_CTRL: d.rdata = ctrl_w;
                OFS_SPACE: d.rdata = space_w;
                OFS_ADDR: d.rdata = q.addr;
                OFS_CMD: d.rdata = cmd_w;
                OFS_STATUS: d.rdata = stat_w;
                default: d.rdata = 32'h0;
            endcase
        end
        if (sel_ok && wb_we_i) begin
            case (wb_adr_i)
                OFS_CTRL: begin
                    wv = merge(ctrl_w, wb_dat_i, wb_sel_i);
                    d.div_sel = div_sel_t'(wv[CTRL_DIV_LSB +: 2]);
                    d.no_sdram = wv[CTRL_NOSD_BIT];
                    d.self_ref = wv[CTRL_SREF_BIT];
                    d.gpo_val = wv[CTRL_GPO_BIT];
                    d.mem_width = wv[CTRL_WID_LSB +: 2];
                end
                OFS_SPACE: begin
                    wv = merge(space_w, wb_dat_i, wb_sel_i);
                    d.space_type = wv[7:0];
                    d.rd_sel = wv[SPACE_RDSEL_LSB +: 4];
                end
                OFS_ADDR: begin
                    if (!q.pend) begin
                        d.addr = merge(q.addr, wb_dat_i, wb_sel_i);
                    end
                end
                OFS_CMD: begin
                    if (!q.pend) begin
                        wv = merge(cmd_w, wb_dat_i, wb_sel_i);
                        d.cmd_we = wv[CMD_WE_BIT];
                        d.cmd_px = wv[CMD_PX_BIT];
                        d.cmd_size = wv[CMD_SIZE_LSB +: 2];
                        d.pend = 1'b1;
                    end
                end
                OFS_STATUS: begin
                    if (wb_sel_i[0] && wb_dat_i[STAT_DONE_BIT]) begin
                        d.done = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (done_set) begin
            d.done = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.mem_width <= WIDTH_RST;
            q.fsm <= ST_IDLE;
            q.ce_n <= 4'hf;
            q.be_n <= 8'hff;
            q.rd_n <= 1'b1;
            q.oe_n <= 1'b1;
            q.we_n <= 1'b1;
            q.fifo3_n <= 1'b1;
            q.px_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign wb_dat_o = q.rdata;
    assign wb_ack_o = q.ack;
    assign if_clk_out_full_o = q.src_lvl;
    assign if_clk_out_div_o = q.div_lvl;
    assign chip_en_n_o = q.ce_n;
    assign byte_en_n_o = q.be_n;
    assign pin_rd_n_o = q.rd_n;
    assign pin_oe_n_o = q.oe_n;
    assign pin_we_n_o = q.we_n;
    assign fifo_out_en_space3_n_o = q.fifo3_n;
    assign periph_xfer_out_n_o = q.px_n;
    assign ctl_oe_n_o = q.bus_off;
    assign hold_ack_out_o = q.hold_ack;
    assign sdram_clk_en_o = q.no_sdram ? q.gpo_val : !q.self_ref;
    assign bus_req_out_o = q.pend;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_one_chip_en: assert property ($onehot0(~chip_en_n_o))
        else $error("more than one chip enable active");
    a_hold_floats: assert property (hold_ack_out_o |-> ctl_oe_n_o
        && chip_en_n_o == 4'hf)
        else $error("hold acknowledged while driving");
    a_hold_after_off: assert property ($rose(hold_ack_out_o)
        |-> $past(ctl_oe_n_o))
        else $error("hold acknowledged before bus released");
    a_hold_answer: assert property ((hold_req_in_i && q.fsm == ST_IDLE)
        ##1 hold_req_in_i [*2] |-> hold_ack_out_o)
        else $error("hold request not answered");
    a_cke_gpo_mode: assert property (q.no_sdram
        |-> sdram_clk_en_o == q.gpo_val)
        else $error("clock enable not following gpo");
    a_cke_self_ref: assert property ((!q.no_sdram && $rose(q.self_ref))
        |-> !sdram_clk_en_o)
        else $error("clock enable high in self refresh");
    a_fifo_space3: assert property (!fifo_out_en_space3_n_o
        |-> !chip_en_n_o[3] && pin_we_n_o)
        else $error("fifo enable outside space 3 read");
    a_rd_sel_read: assert property ((!pin_rd_n_o && q.fsm == ST_STROBE
        && mtype == MEM_SYNC && q.rd_sel[space]) |-> !q.cmd_we)
        else $error("sync read enable on a write");
    a_async_wait: assert property ((q.fsm == ST_STROBE
        && mtype == MEM_ASYNC && !async_ready_in_i)
        |=> q.fsm == ST_STROBE && !pin_rd_n_o == !q.cmd_we)
        else $error("async access ended without ready");
    a_sdram_ras: assert property ((q.fsm == ST_ACTIVE && mtype == MEM_SDRAM)
        |-> !pin_oe_n_o && pin_rd_n_o)
        else $error("row strobe missing");
    a_write_strobe: assert property ((q.fsm == ST_STROBE && q.cmd_we)
        |-> !pin_we_n_o)
        else $error("write strobe missing");
    a_periph_strobe: assert property (!periph_xfer_out_n_o
        |-> q.fsm == ST_STROBE && q.cmd_px)
        else $error("peripheral strobe out of place");
    a_ext_clk_full: assert property ((q.strap_done && $past(q.strap_done)
        && q.clk_src == SRC_EXT) |-> if_clk_out_full_o
        == $past(if_clk_in_i))
        else $error("full clock not following input");
    a_strap_pick: assert property ($rose(q.strap_done)
        |-> q.clk_src == strap_decode($past(clk_src_straps_i)))
        else $error("clock source not from straps");
    a_div_toggle: assert property ((q.div_sel != DIV_1
        && $stable(q.div_sel) && $changed(if_clk_out_div_o))
        |-> $rose(if_clk_out_full_o))
        else $error("divided clock edge off source edge");
    a_bus_req_hold: assert property ((q.fsm == ST_HOLD && q.pend)
        |-> bus_req_out_o)
        else $error("bus request missing in hold");
    a_byte_en: assert property ((q.fsm == ST_ACTIVE && q.mem_width == 2'h0)
        |-> byte_en_n_o[7:1] == 7'h7f)
        else $error("byte enable beyond memory width");

    c_hold_grant: cover property ($rose(hold_ack_out_o));
    c_async_wait: cover property (q.fsm == ST_STROBE && mtype == MEM_ASYNC
        && !async_ready_in_i ##1 q.fsm == ST_DONE);
    c_fifo_read: cover property (!fifo_out_en_space3_n_o);
    c_sdram_write: cover property (q.fsm == ST_STROBE && mtype == MEM_SDRAM
        && q.cmd_we);

endmodule
`default_nettype wire

// File: emif_mem_model.sv
// far-side model: async memory ready with wait states
// assumes strobes are registered on clk_i, ready pulled up when idle
`timescale 1ns/1ns
`default_nettype none
module emif_mem_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] waits_i,
    input wire logic pin_rd_n_i,
    input wire logic pin_we_n_i,
    output logic ready_o
);
    // ************************************************************
    // wait-state counter
    // ************************************************************
    logic [3:0] cnt_q;
    logic strobe;
    assign strobe = !pin_rd_n_i || !pin_we_n_i;
    always_ff @(posedge clk_i) begin
        if (rst_i || !strobe) begin
            cnt_q <= 4'h0;
        end else if (cnt_q != 4'hf) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    // low for the wait states, else pulled up
    assign ready_o = !(strobe && cnt_q < waits_i);
endmodule
`default_nettype wire

// File: emif_ctl_bench.sv
// self-checking bench of the memory control pin block
// assumes the memory model answers the ready input
`timescale 1ns/1ns
`default_nettype none
module emif_ctl_bench;
    import emif_ctl_pkg::*;
    // ************************************************************
    // signals
    // ************************************************************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, d;
    logic wb_we_i = 1'b0, wb_stb_i = 1'b0, wb_cyc_i = 1'b0, wb_ack_o;
    logic [3:0] wb_sel_i = 4'h0, chip_en_n_o, waits = 4'h0, ce_and;
    logic [1:0] clk_src_straps_i = 2'h0;
    logic if_clk_in_i = 1'b0, hold_req_in_i = 1'b0, async_ready_in_i;
    logic [7:0] byte_en_n_o, be_and;
    logic if_clk_out_full_o, if_clk_out_div_o, pin_rd_n_o, pin_oe_n_o;
    logic pin_we_n_o, sdram_clk_en_o, fifo_out_en_space3_n_o;
    logic periph_xfer_out_n_o, ctl_oe_n_o, hold_ack_out_o, bus_req_out_o;
    logic oe_seen, we_seen, fifo_seen, px_seen, pf, pd;
    int n_errors = 0, comparisons = 0, cycles = 0, rd_cnt, n_full, n_div;
    int e;
    logic [31:0] ctv[4] = '{32'h68, 32'h74, 32'h64, 32'h60};
    logic cke[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    clk_src_t srcs[4] = '{SRC_EXT, SRC_CORE4, SRC_CORE6, SRC_EXT};
    int per[4] = '{2, 4, 6, 2};
    logic [7:0] bev[3] = '{8'hfe, 8'hfc, 8'hf3};

    always #4 clk_i = !clk_i;
    always @(posedge clk_i) if_clk_in_i <= !if_clk_in_i;

    emif_ctl emif_ctl_inst (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
        .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_stb_i, .wb_cyc_i, .wb_ack_o,
        .clk_src_straps_i, .if_clk_in_i, .if_clk_out_full_o,
        .if_clk_out_div_o, .chip_en_n_o, .byte_en_n_o, .pin_rd_n_o,
        .pin_oe_n_o, .pin_we_n_o, .sdram_clk_en_o, .fifo_out_en_space3_n_o,
        .periph_xfer_out_n_o, .ctl_oe_n_o, .async_ready_in_i,
        .hold_req_in_i, .hold_ack_out_o, .bus_req_out_o);
    emif_mem_model emif_mem_model_inst (.clk_i, .rst_i, .waits_i(waits),
        .pin_rd_n_i(pin_rd_n_o), .pin_we_n_i(pin_we_n_o),
        .ready_o(async_ready_in_i));

    // ************************************************************
    // monitor and timeout
    // ************************************************************
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 20000) begin
            n_errors++;
            finish_test();
        end
        if (if_clk_out_full_o && !pf) n_full++;
        if (if_clk_out_div_o && !pd) n_div++;
        pf = if_clk_out_full_o;
        pd = if_clk_out_div_o;
        if (chip_en_n_o != 4'hf) begin
            ce_and &= chip_en_n_o;
            be_and &= byte_en_n_o;
        end
        rd_cnt += int'(!pin_rd_n_o);
        oe_seen |= !pin_oe_n_o;
        we_seen |= !pin_we_n_o;
        fifo_seen |= !fifo_out_en_space3_n_o;
        px_seen |= !periph_xfer_out_n_o;
        if (hold_ack_out_o === 1'b1 && ctl_oe_n_o !== 1'b1) begin
            n_errors++;
            $display("unexpected at %0t: granted while driving", $time);
        end
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic clr();
        rd_cnt = 0;
        n_full = 0;
        n_div = 0;
        ce_and = 4'hf;
        be_and = 8'hff;
        {oe_seen, we_seen, fifo_seen, px_seen} = 4'h0;
    endtask

    task automatic do_reset(input logic [1:0] s);
        clk_src_straps_i <= s;
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] v);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hf};
        wb_adr_i <= a;
        wb_dat_i <= v;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        d = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask

    task automatic wait_done();
        repeat (200) begin
            wb(1'b0, OFS_STATUS, 32'h0);
            if (d[STAT_DONE_BIT] === 1'b1) break;
        end
        wb(1'b1, OFS_STATUS, 32'h4);
    endtask

    task automatic start(input logic [31:0] a, input logic [31:0] c);
        clr();
        wb(1'b1, OFS_ADDR, a);
        wb(1'b1, OFS_CMD, c);
    endtask

    task automatic finish_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        do_reset(2'h0);
        chk(chip_en_n_o === 4'hf && sdram_clk_en_o === 1'b1, "reset pins");
        wb(1'b0, OFS_CTRL, 32'h0);
        chk(d === 32'h60, "ctrl reset value");
        wb(1'b0, 8'h14, 32'h0);
        chk(d === 32'h0, "unmapped read");
        foreach (ctv[i]) begin
            wb(1'b1, OFS_CTRL, ctv[i]);
            @(posedge clk_i);
            chk(sdram_clk_en_o === cke[i], "clock enable pin");
        end
        $display("test registers done");
        wb(1'b1, OFS_SPACE, 32'h8a4);
        for (int s = 0; s < 4; s++) begin
            for (int w = 0; w < 2; w++) begin
                start({2'h0, 2'(s), 25'h0, 3'(2 * s + 1)}, {30'h0, 1'(s), 1'(w)});
                wait_done();
                chk(ce_and === ~(4'h1 << s), "chip enable");
                chk(be_and === ~(8'h1 << (2 * s + 1)), "byte enable");
                chk((rd_cnt > 0) === (!w || s == 1 || s == 2), "read pin");
                chk(oe_seen === (!w || s == 1), "oe pin");
                chk(we_seen === 1'(w), "write pin");
                chk(fifo_seen === (s == 3 && !w), "fifo oe");
                chk(px_seen === 1'(s), "transfer strobe");
            end
        end
        for (int i = 0; i < 2; i++) begin
            waits <= 4'(6 * i);
            start(32'h0, 32'h0);
            wait_done();
            chk((rd_cnt >= 6) === (i == 1), "wait states");
        end
        $display("test accesses done");
        hold_req_in_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(hold_ack_out_o === 1'b1 && ctl_oe_n_o === 1'b1, "grant");
        start(32'h0, 32'h0);
        repeat (4) @(posedge clk_i);
        chk(bus_req_out_o === 1'b1 && rd_cnt == 0, "request in hold");
        hold_req_in_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(hold_ack_out_o === 1'b0, "release");
        wait_done();
        chk(rd_cnt > 0, "access after hold");
        start(32'h0, 32'h0);
        repeat (100) if (pin_rd_n_o !== 1'b0) @(posedge clk_i);
        hold_req_in_i <= 1'b1;
        repeat (100) if (hold_ack_out_o !== 1'b1) @(posedge clk_i);
        chk(rd_cnt >= 6 && bus_req_out_o === 1'b0, "hold after access");
        hold_req_in_i <= 1'b0;
        wait_done();
        $display("test hold done");
        for (int k = 0; k < 3; k++) begin
            wb(1'b1, OFS_CTRL, 32'(k) << CTRL_WID_LSB);
            start(32'(2 * (k / 2)), 32'(k == 2 ? 4 : 12));
            wait_done();
            chk(be_and === bev[k], "byte enable width");
        end
        $display("test widths done");
        for (int s = 0; s < 4; s++) begin
            do_reset(2'(s));
            wb(1'b0, OFS_STATUS, 32'h0);
            chk(d[4:3] === srcs[s], "clock source");
            for (int v = 0; v < 3; v++) begin
                wb(1'b1, OFS_CTRL, 32'h60 | v);
                repeat (8) @(posedge clk_i);
                clr();
                repeat (96) @(posedge clk_i);
                e = 96 / per[s];
                chk(n_full >= e - 1 && n_full <= e + 1, "full clock");
                e = e >> v;
                chk(n_div >= e - 1 && n_div <= e + 1, "divided clock");
            end
        end
        $display("test clocks done");
        finish_test();
    end
endmodule
`default_nettype wire
